// >>> inc/mtc_pin_if.sv
`timescale 1ns/1ps
interface mtc_pin_if;
  logic bypass;
  logic level;
  logic rise;
  logic fall;
  modport filt (input bypass, output level, output rise, output fall);
  modport core (output bypass, input level, input rise, input fall);
endinterface

// >>> inc/mtc_pkg.sv
package mtc_pkg;

  // Register byte addresses on the Wishbone slave.
  localparam logic [7:0] ADR_CTRL  = 8'h00;
  localparam logic [7:0] ADR_CMPA  = 8'h04;
  localparam logic [7:0] ADR_CAPB  = 8'h08;
  localparam logic [7:0] ADR_CNT   = 8'h0c;
  localparam logic [7:0] ADR_ISTAT = 8'h10;
  localparam logic [7:0] ADR_IMASK = 8'h14;

  // Widths of the counter, the control word, the prescalers and the filter counter.
  localparam int CNT_W    = 16;
  localparam int CTRL_W   = 10;
  localparam int PRE_W    = 11;
  localparam int FSDIV_W  = 3;
  localparam int FILT_W   = 3;

  // Prescaler taps, as the exponent of the divider.
  localparam int TAP_DIV11 = 11;
  localparam int TAP_DIV7  = 7;
  localparam int TAP_DIV3  = 3;

  // Start control codes.
  localparam logic [1:0] START_STOP = 2'h0;
  localparam logic [1:0] START_CMD  = 2'h1;
  localparam logic [1:0] START_RISE = 2'h2;
  localparam logic [1:0] START_FALL = 2'h3;

  // Source clock select codes.
  localparam logic [1:0] SRC_DIV11 = 2'h0;
  localparam logic [1:0] SRC_DIV7  = 2'h1;
  localparam logic [1:0] SRC_DIV3  = 2'h2;
  localparam logic [1:0] SRC_PIN   = 2'h3;

  // Operating mode codes; only the basic family counts in this block.
  localparam logic [1:0] MODE_BASIC  = 2'h0;
  localparam logic [1:0] MODE_WINDOW = 2'h1;
  localparam logic [1:0] MODE_PULSE  = 2'h2;
  localparam logic [1:0] MODE_PPG    = 2'h3;

  // Noise rejection: unless slow_mode bypasses the filter, pulses this many fc periods or shorter are dropped.
  localparam int FILT_REJECT_FC  = 4;
  localparam int FC_PER_MCLK     = 1;
  localparam int FILT_REJECT_CYC = FILT_REJECT_FC * FC_PER_MCLK;

  // Values after reset.
  localparam logic [CNT_W-1:0]  CMPA_RST  = 16'hffff;
  localparam logic [CTRL_W-1:0] CTRL_RST  = 10'h000;
  localparam logic              IMASK_RST = 1'b0;

  // Control word layout, low bit last.
  typedef struct packed {
    logic       slow_mode;
    logic       prescaler_tap_select;
    logic       auto_capture_enable;
    logic       trigger_stop_select;
    logic [1:0] mode_select;
    logic [1:0] source_clock_select;
    logic [1:0] start_control;
  } mtc_ctrl_t;

  // Run state of the external trigger timer.
  typedef enum logic {MTC_HALT, MTC_RUN} mtc_run_t;

endpackage

// >>> verification/mtc_pulse_src.sv
`timescale 1ns/1ps
module mtc_pulse_src (
  // Clock.
  input  wire logic mclk_in,
  // Driven timer pin.
  output logic      pin_out
);
  // The pin starts low until the bench picks a rest level.
  initial pin_out = 1'b0;

  // Sets the rest level between pulses.
  task automatic set_idle(input logic b);
    @(posedge mclk_in);
    pin_out <= b;
  endtask

  // pulse hold times
  // Inverts the pin for hi cycles, then rests lo cycles; short widths are deliberate glitches.
  task automatic pulse(input int hi, input int lo);
    @(posedge mclk_in);
    pin_out <= ~pin_out;
    repeat (hi) @(posedge mclk_in);
    pin_out <= ~pin_out;
    repeat (lo) @(posedge mclk_in);
  endtask
endmodule

// >>> verification/mtc_top_assertions.sv
`timescale 1ns/1ps
module mtc_top_assertions (
  // Watched ports.
  input wire logic        mclk_in,
  input wire logic        rst_in,
  input wire logic        wb_cyc_in,
  input wire logic        wb_stb_in,
  input wire logic        wb_we_in,
  input wire logic [7:0]  wb_adr_in,
  input wire logic [3:0]  wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic        wb_ack_out,
  input wire logic        timer_input_pin_in,
  input wire logic        fs_clk_in,
  input wire logic        irq_out
);
  import mtc_pkg::*;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  // Bus answers come one cycle after a request and last one cycle.
  a_ack_follows: assert property (
    wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out) else $error("ack missing");
  a_ack_single: assert property (
    wb_ack_out |=> !wb_ack_out) else $error("ack too long");
  a_ack_cause: assert property (
    wb_ack_out |-> $past(wb_cyc_in && wb_stb_in)) else $error("ack without request");
  // Read data only moves with an answer, and is zero for writes and holes.
  a_dat_hold: assert property (
    $changed(wb_dat_out) |-> wb_ack_out) else $error("read data moved");
  a_write_zero: assert property (
    wb_ack_out && $past(wb_we_in) |-> wb_dat_out == 32'h0) else $error("write data nonzero");
  a_hole_zero: assert property (
    wb_ack_out && !$past(wb_we_in) && $past(wb_adr_in) > ADR_IMASK |-> wb_dat_out == 32'h0)
    else $error("unmapped read nonzero");
  // The interrupt only drops by a bus access, and a cleared mask silences it.
  a_irq_fall: assert property (
    $fell(irq_out) |-> wb_ack_out) else $error("irq dropped alone");
  a_irq_masked: assert property (
    wb_ack_out && $past(wb_we_in && wb_adr_in == ADR_IMASK && wb_sel_in[0] && !wb_dat_in[0])
    |-> !irq_out) else $error("masked irq high");

  // Main scenarios reached.
  c_irq: cover property ($rose(irq_out));
  c_status: cover property (wb_ack_out && $past(wb_adr_in == ADR_ISTAT));
  c_pin: cover property ($rose(timer_input_pin_in));
endmodule

bind mtc_top mtc_top_assertions u_chk (.mclk_in, .rst_in, .wb_cyc_in, .wb_stb_in, .wb_we_in,
  .wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out, .timer_input_pin_in,
  .fs_clk_in, .irq_out);

// >>> verification/tb_mtc_top.sv
`timescale 1ns/1ps
module tb_mtc_top;
  import mtc_pkg::*;
  logic        mclk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        wb_cyc_in = 1'b0;
  logic        wb_stb_in = 1'b0;
  logic        wb_we_in = 1'b0;
  logic [7:0]  wb_adr_in = 8'h00;
  logic [3:0]  wb_sel_in = 4'h0;
  logic [31:0] wb_dat_in = 32'h0;
  logic [31:0] wb_dat_out;
  logic        wb_ack_out;
  logic        pin;
  logic        irq_out;
  logic        fs_clk = 1'b0;
  int          err_count = 0;
  int          total_checks = 0;
  int          cycles = 0;

  // Clock at 40 MHz.
  always #12.5 mclk_in = ~mclk_in;

  // Block under test and the pulse source on its pin.
  mtc_top dut (.mclk_in, .rst_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in,
    .wb_dat_in, .wb_dat_out, .wb_ack_out, .timer_input_pin_in(pin), .fs_clk_in(fs_clk), .irq_out);
  mtc_pulse_src src (.mclk_in, .pin_out(pin));

  // Cuts a hung run short and makes a slow fs clock of sixteen cycles.
  always @(posedge mclk_in) begin
    cycles <= cycles + 1;
    fs_clk <= cycles[3];
    if (cycles == 30000) begin
      err_count++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One classic cycle, held until ack is sampled high.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge mclk_in);
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in  <= w;
    wb_adr_in <= a;
    wb_sel_in <= 4'hf;
    wb_dat_in <= d;
    do begin
      @(posedge mclk_in);
      n++;
    end while (wb_ack_out !== 1'b1);
    q = wb_dat_out;
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
    chk("ack wait", 32'h2, 32'(n));
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk($sformatf("reg %h", a), exp, q);
  endtask

  task automatic wirq(input int lim, output int n);
    n = 0;
    while (irq_out !== 1'b1 && n < lim) begin
      @(posedge mclk_in);
      n++;
    end
  endtask

  task automatic t_reset();
    logic [7:0]  adr[7] = '{ADR_CTRL, ADR_CMPA, ADR_CAPB, ADR_CNT, ADR_ISTAT, ADR_IMASK, 8'h40};
    logic [31:0] val[7] = '{32'h0, 32'hffff, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
    wr(ADR_CNT, 32'h5);
    wr(ADR_CAPB, 32'h5);
    wr(8'h40, 32'h5);
    for (int i = 0; i < 7; i++) rc(adr[i], val[i]);
  endtask

  task automatic t_timer();
    int p[3] = '{8, 128, 2048};
    int n;
    logic [31:0] q;
    wr(ADR_IMASK, 32'h1);
    wr(ADR_CTRL, 32'h08);
    wr(ADR_CMPA, 32'h3);
    for (int i = 0; i < 3; i++) begin
      wr(ADR_CTRL, 32'h0);
      wr(ADR_CTRL, 32'h81 | ((2 - i) << 2));
      wirq(4 * p[i] + 8, n);
      chk("match time", 32'h1, 32'(n >= 3 * p[i] - 2 && irq_out === 1'b1));
      rc(ADR_ISTAT, 32'h1);
      rc(ADR_ISTAT, 32'h0);
    end
    bus(1'b0, ADR_CNT, 32'h0, q);
    rc(ADR_CAPB, (q == 32'h0) ? 32'h3 : q - 32'h1);
    wr(ADR_CTRL, 32'h0);
    wr(ADR_CTRL, 32'h09);
    wr(ADR_IMASK, 32'h0);
    repeat (40) @(posedge mclk_in);
    chk("masked irq", 32'h0, {31'h0, irq_out});
    rc(ADR_ISTAT, 32'h1);
    wr(ADR_IMASK, 32'h1);
  endtask

  task automatic t_ext();
    int n;
    wr(ADR_CTRL, 32'h0);
    wr(ADR_CTRL, 32'h4a);
    rc(ADR_ISTAT, 32'h0);
    wirq(100, n);
    chk("idle before trigger", 32'h0, {31'h0, irq_out});
    src.pulse(60, 20);
    chk("trigger match", 32'h1, {31'h0, irq_out});
    rc(ADR_ISTAT, 32'h1);
    src.pulse(14, 60);
    chk("opposite edge stop", 32'h0, {31'h0, irq_out});
    rc(ADR_CNT, 32'h0);
    src.pulse(60, 20);
    chk("restart", 32'h1, {31'h0, irq_out});
    rc(ADR_ISTAT, 32'h1);
    wr(ADR_CTRL, 32'h0);
    wr(ADR_CTRL, 32'h0a);
    src.pulse(14, 60);
    chk("opposite ignored", 32'h1, {31'h0, irq_out});
    rc(ADR_ISTAT, 32'h1);
    wr(ADR_CTRL, 32'h0);
    wr(ADR_CTRL, 32'h0b);
    src.pulse(14, 60);
    chk("falling trigger", 32'h1, {31'h0, irq_out});
    rc(ADR_ISTAT, 32'h1);
  endtask

  task automatic t_slow();
    int n;
    for (int i = 0; i < 2; i++) begin
      wr(ADR_CTRL, 32'h0);
      wr(ADR_CTRL, 32'h001 | (32'h100 << i));
      wirq(4 * 128 + 40, n);
      chk("fs tick time", 32'h1, 32'(n >= 3 * 128 - 2 && irq_out === 1'b1));
      rc(ADR_ISTAT, 32'h1);
    end
    wr(ADR_CTRL, 32'h0);
    wr(ADR_CTRL, 32'h20e);
    src.pulse(4, 16);
    rc(ADR_CNT, 32'h1);
    wr(ADR_CTRL, 32'h0);
    wr(ADR_CTRL, 32'h19);
    repeat (40) @(posedge mclk_in);
    rc(ADR_CNT, 32'h0);
    rc(ADR_ISTAT, 32'h0);
    wr(ADR_CTRL, 32'h0);
  endtask

  task automatic t_event();
    for (int s = 2; s < 4; s++) begin
      wr(ADR_CTRL, 32'h0);
      src.set_idle(s == 3);
      repeat (12) @(posedge mclk_in);
      wr(ADR_CTRL, 32'h0c | s);
      src.pulse(4, 16);
      rc(ADR_CNT, 32'h0);
      src.pulse(12, 16);
      rc(ADR_CNT, 32'h1);
      src.pulse(12, 16);
      src.pulse(12, 16);
      chk("event match", 32'h1, {31'h0, irq_out});
      rc(ADR_CNT, 32'h0);
      rc(ADR_ISTAT, 32'h1);
    end
  endtask

  // Reset, then the scenarios in turn.
  initial begin
    repeat (5) @(posedge mclk_in);
    rst_in <= 1'b0;
    t_reset();
    t_timer();
    t_ext();
    t_event();
    t_slow();
    wrap_up();
  end
endmodule

// >>> verilog/mtc_filter.sv
`timescale 1ns/1ps
module mtc_filter #(
  parameter int REJECT_CYC = mtc_pkg::FILT_REJECT_CYC
) (
  // Clock and reset.
  input  wire logic  mclk_in,
  input  wire logic  rst_in,
  // Raw timer input pin.
  input  wire logic  pin_in,
  // Filtered level and edges.
  mtc_pin_if.filt    pin_if
);
  import mtc_pkg::*;

  typedef struct packed {
    logic              s1;
    logic              s2;
    logic              level;
    logic [FILT_W-1:0] cnt;
    logic              rise;
    logic              fall;
  } mtc_filt_t;

  mtc_filt_t s_r;
  mtc_filt_t s_nxt;

  // Synchronise, then accept a level once it outlasts the reject time, or at once when bypass is set.
  always_comb begin
    s_nxt = s_r;
    s_nxt.s1 = pin_in;
    s_nxt.s2 = s_r.s1;
    s_nxt.rise = 1'b0;
    s_nxt.fall = 1'b0;
    if (s_r.s2 == s_r.level) begin
      s_nxt.cnt = '0;
    end else if (pin_if.bypass) begin
      s_nxt.level = s_r.s2;
      s_nxt.rise = s_r.s2;
      s_nxt.fall = ~s_r.s2;
      s_nxt.cnt = '0;
    end else if (s_r.cnt == FILT_W'(REJECT_CYC)) begin
      s_nxt.level = s_r.s2;
      s_nxt.rise = s_r.s2;
      s_nxt.fall = ~s_r.s2;
      s_nxt.cnt = '0;
    end else begin
      s_nxt.cnt = s_r.cnt + 1'b1;
    end
  end

  // State register.
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Filtered outputs.
  assign pin_if.level = s_r.level;
  assign pin_if.rise  = s_r.rise;
  assign pin_if.fall  = s_r.fall;

endmodule

// >>> verilog/mtc_top.sv
`timescale 1ns/1ps
module mtc_top #(
  parameter int FILTER_REJECT_CYC = mtc_pkg::FILT_REJECT_CYC
) (
  // Clock and reset.
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  // Wishbone classic slave.
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output wire logic [31:0] wb_dat_out,
  output wire logic        wb_ack_out,
  // Pins.
  input  wire logic        timer_input_pin_in,
  input  wire logic        fs_clk_in,
  // Interrupt.
  output wire logic        irq_out
);
  import mtc_pkg::*;

  typedef struct packed {
    mtc_ctrl_t          ctrl;
    logic [CNT_W-1:0]   cmp_stage;
    logic               cmp_pend;
    logic [CNT_W-1:0]   compare_register_a;
    logic [CNT_W-1:0]   capture_register_b;
    logic [CNT_W-1:0]   cnt;
    mtc_run_t           run;
    logic [PRE_W-1:0]   pre;
    logic [FSDIV_W-1:0] fsdiv;
    logic               fs_s1;
    logic               fs_s2;
    logic               fs_s3;
    logic               irq_st;
    logic               irq_mask;
    logic               ack;
    logic [31:0]        rdat;
  } mtc_state_t;

  mtc_state_t       s_r;
  mtc_state_t       s_nxt;
  mtc_pin_if        pin_if ();

  logic             fs_tick;
  logic             int_tick;
  logic             cnt_edge;
  logic             opp_edge;
  logic             src_edge;
  logic             basic;
  logic             on_pin;
  logic             is_timer;
  logic             is_ext;
  logic             is_event;
  logic             match;
  logic             cnt_tick;
  logic             req;
  logic             irq_set;
  logic             irq_clr;
  logic [CTRL_W-1:0] ctrl_w;

  // Pin synchroniser and noise filter.
  mtc_filter #(
    .REJECT_CYC (FILTER_REJECT_CYC)
  ) u_filter (
    .mclk_in (mclk_in),
    .rst_in  (rst_in),
    .pin_in  (timer_input_pin_in),
    .pin_if  (pin_if)
  );

  assign pin_if.bypass = s_r.ctrl.slow_mode;

  // Prescaler taps and mode decode.
  always_comb begin
    fs_tick = (s_r.fs_s2 & ~s_r.fs_s3) & (s_r.fsdiv == {FSDIV_W{1'b1}});
    int_tick = 1'b0;
    case (s_r.ctrl.source_clock_select)
      SRC_DIV11: begin
        if (s_r.ctrl.prescaler_tap_select || s_r.ctrl.slow_mode) begin
          int_tick = fs_tick;
        end else begin
          int_tick = (s_r.pre[TAP_DIV11-1:0] == {TAP_DIV11{1'b1}});
        end
      end
      SRC_DIV7: begin
        int_tick = (s_r.pre[TAP_DIV7-1:0] == {TAP_DIV7{1'b1}});
      end
      SRC_DIV3: begin
        int_tick = (s_r.pre[TAP_DIV3-1:0] == {TAP_DIV3{1'b1}});
      end
      default: begin
        int_tick = 1'b0;
      end
    endcase
    cnt_edge = (s_r.ctrl.start_control == START_FALL) ? pin_if.fall : pin_if.rise;
    opp_edge = (s_r.ctrl.start_control == START_FALL) ? pin_if.rise : pin_if.fall;
    on_pin   = (s_r.ctrl.source_clock_select == SRC_PIN);
    src_edge = on_pin ? cnt_edge : int_tick;
    basic    = (s_r.ctrl.mode_select == MODE_BASIC);
    is_timer = basic & ~on_pin & (s_r.ctrl.start_control == START_CMD);
    is_ext   = basic & ~on_pin & s_r.ctrl.start_control[1];
    is_event = basic & on_pin & s_r.ctrl.start_control[1];
    match    = (s_r.cnt == s_r.compare_register_a);
    cnt_tick = is_timer ? int_tick : (is_event ? cnt_edge : 1'b0);
    req      = wb_cyc_in & wb_stb_in & ~s_r.ack;
    irq_clr  = req & ~wb_we_in & (wb_adr_in == ADR_ISTAT);
  end

  // Next state: bus, prescalers, counter, capture and interrupt.
  always_comb begin
    s_nxt = s_r;
    irq_set = 1'b0;
    ctrl_w = s_r.ctrl;
    s_nxt.ack = 1'b0;
    s_nxt.fs_s1 = fs_clk_in;
    s_nxt.fs_s2 = s_r.fs_s1;
    s_nxt.fs_s3 = s_r.fs_s2;
    s_nxt.pre = s_r.pre + 1'b1;
    if (s_r.fs_s2 & ~s_r.fs_s3) begin
      s_nxt.fsdiv = s_r.fsdiv + 1'b1;
    end

    if (s_r.cmp_pend && src_edge) begin
      s_nxt.compare_register_a = s_r.cmp_stage;
      s_nxt.cmp_pend = 1'b0;
    end

    // Counter modes.
    // stopped state clears counter
    if ((s_r.ctrl.start_control == START_STOP) || !basic) begin
      s_nxt.cnt = '0;
      s_nxt.run = MTC_HALT;
    end else if (is_timer) begin
      if (int_tick) begin
        if (match) begin
          s_nxt.cnt = '0;
          irq_set = 1'b1;
        end else begin
          s_nxt.cnt = s_r.cnt + 1'b1;
        end
      end
    end else if (is_ext) begin
      case (s_r.run)
        MTC_HALT: begin
          if (cnt_edge) begin
            s_nxt.run = MTC_RUN;
          end
        end
        MTC_RUN: begin
          if (s_r.ctrl.trigger_stop_select && opp_edge) begin
            s_nxt.cnt = '0;
            s_nxt.run = MTC_HALT;
          end else if (int_tick && match) begin
            s_nxt.cnt = '0;
            s_nxt.run = MTC_HALT;
            irq_set = 1'b1;
          end else if (int_tick) begin
            s_nxt.cnt = s_r.cnt + 1'b1;
          end
        end
        default: begin
          s_nxt.run = MTC_HALT;
        end
      endcase
    end else if (is_event) begin
      if (cnt_edge) begin
        s_nxt.cnt = s_r.cnt + 1'b1;
      end else if (opp_edge && match) begin
        s_nxt.cnt = '0;
        irq_set = 1'b1;
      end
    end

    if (s_r.ctrl.auto_capture_enable && cnt_tick) begin
      s_nxt.capture_register_b = s_r.cnt;
    end

    // Register access; one wait state, ack for one cycle.
    if (req) begin
      s_nxt.ack = 1'b1;
      case (wb_adr_in)
        ADR_CTRL:  s_nxt.rdat = {22'h000000, s_r.ctrl};
        ADR_CMPA:  s_nxt.rdat = {16'h0000, s_r.compare_register_a};
        ADR_CAPB:  s_nxt.rdat = {16'h0000, s_r.capture_register_b};
        ADR_CNT:   s_nxt.rdat = {16'h0000, s_r.cnt};
        ADR_ISTAT: s_nxt.rdat = {31'h00000000, s_r.irq_st};
        ADR_IMASK: s_nxt.rdat = {31'h00000000, s_r.irq_mask};
        default:   s_nxt.rdat = 32'h00000000;
      endcase
      if (wb_we_in) begin
        s_nxt.rdat = 32'h00000000;
        case (wb_adr_in)
          ADR_CTRL: begin
            if (wb_sel_in[0]) begin
              ctrl_w[7:0] = wb_dat_in[7:0];
            end
            if (wb_sel_in[1]) begin
              ctrl_w[CTRL_W-1:8] = wb_dat_in[CTRL_W-1:8];
            end
            s_nxt.ctrl = ctrl_w;
          end
          ADR_CMPA: begin
            if (wb_sel_in[0]) begin
              s_nxt.cmp_stage[7:0] = wb_dat_in[7:0];
            end
            if (wb_sel_in[1]) begin
              s_nxt.cmp_stage[15:8] = wb_dat_in[15:8];
              s_nxt.cmp_pend = 1'b1;
            end
          end
          ADR_IMASK: begin
            if (wb_sel_in[0]) begin
              s_nxt.irq_mask = wb_dat_in[0];
            end
          end
          default: begin
            s_nxt.cmp_pend = s_nxt.cmp_pend;
          end
        endcase
      end
    end

    // Sticky match flag; a new event wins over the read clear.
    s_nxt.irq_st = irq_set | (s_r.irq_st & ~irq_clr);
  end

  // State register with synchronous reset.
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      s_r <= '0;
      s_r.ctrl <= CTRL_RST;
      s_r.cmp_stage <= CMPA_RST;
      s_r.compare_register_a <= CMPA_RST;
      s_r.irq_mask <= IMASK_RST;
      s_r.run <= MTC_HALT;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs.
  assign wb_dat_out = s_r.rdat;
  assign wb_ack_out = s_r.ack;
  assign irq_out    = s_r.irq_st & s_r.irq_mask;

endmodule
